// file: pkg/dsrp_pkg.sv
// constants, state type and command encodings of the serial register port
// assumes a single 125 MHz clock domain for everything that includes it
package dsrp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int NUM_CONV = 4;
  localparam int CODE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 16;
  // fixed upper slave address bits
  localparam logic [2:0] ADDR_FIXED = 3'h2;
  // bit counter positions inside a nine-clock byte
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // command byte fields
  localparam int CMD_OP_HI = 7;
  localparam int CMD_OP_LO = 6;
  localparam int CMD_NV_BIT = 5;
  localparam int CMD_V_BIT = 4;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [3:0] SEL_ALL = 4'hf;
  // register type selection {persistent, live}
  localparam logic [1:0] TY_COPY = 2'h0;
  localparam logic [1:0] TY_LIVE = 2'h1;
  localparam logic [1:0] TY_STORED = 2'h2;
  localparam logic [1:0] TY_BOTH = 2'h3;
  // reset and forced values
  localparam logic [7:0] FACTORY_CODE = 8'h00;
  localparam logic [7:0] LIVE_RESET = 8'h00;
  localparam logic [7:0] MUTE_CODE = 8'h00;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_CMD = 5'h04,
    ST_DATA = 5'h08,
    ST_SEND = 5'h10
  } dsrp_state_t;
endpackage : dsrp_pkg

// file: pkg/dsrp_fifo_if.sv
// handshake bundle between the serial engine and the write queue
// assumes both ends share one clock
`timescale 1ns/100ps
interface dsrp_fifo_if #(parameter int WIDTH = 16);
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [WIDTH-1:0] rdData;
  modport fifo(input wrValid, input wrData, input rdReady,
               output wrReady, output rdValid, output rdData);
  modport src(output wrValid, output wrData, input wrReady);
  modport snk(input rdValid, input rdData, output rdReady);
endinterface : dsrp_fifo_if

// file: hw/dsrp_fifo.sv
// synchronous queue with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module dsrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  dsrp_fifo_if.fifo bus
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic doWr, doRd;

  // honest full and empty from the fill count
  assign bus.wrReady = (cnt_q != (PW+1)'(DEPTH));
  assign bus.rdValid = (cnt_q != '0);
  assign bus.rdData = mem[rp_q];
  assign doWr = bus.wrValid & bus.wrReady;
  assign doRd = bus.rdValid & bus.rdReady;

  // pointer and count next values
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (doWr) begin
      wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (doRd) begin
      rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (doWr && !doRd) begin
      cnt_d = cnt_q + 1'b1;
    end else if (doRd && !doWr) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wp_q] <= bus.wrData;
    end
  end
endmodule : dsrp_fifo

// file: hw/dsrp_top.sv
// two-wire slave port and live/stored code registers of a quad converter
// assumes scl, sda, strap and mute pins are asynchronous to clk
//
// Summary of operation
// [RQ1] a live register write changes that converter's output at once
// [RQ2] live codes clear at reset; stored codes survive reset
// [RQ3] after reset every stored code is copied into its live register
// [RQ4] stored codes are zero from the factory (factoryBlank clears them)
// [RQ5] live register loads from serial data or from its stored register
// [RQ6] live and stored registers are both written and read over the port
// [RQ7] general call is not answered; no CBUS support
// [RQ8] only 7-bit addressing; 10-bit headers never match
// [RQ9] bits sampled on scl rise; nine clocks per byte, ninth is acknowledge
// [RQ10] sda change with scl high is a control event, not data
// [RQ11] start is sda fall, stop is sda rise, both with scl high
// [RQ12] stop abandons any transfer; stop in start's high phase may be missed
// [RQ13] repeated start restarts addressing without freeing the bus
// [RQ14] writes may follow each other separated only by repeated starts
// [RQ15] master turns the bus round for reads with a repeated start
// [RQ16] master starts transfers and drives scl at up to 400 kHz
// [RQ17] scl is input only; sda is only ever pulled low
// [RQ18] mute low forces all outputs to low reference code
// [RQ19] four strap pins give the low slave address bits
// [RQ20] shift register decodes command and steers data to registers
// [RQ21] slave address is 010, four strap bits, then read/write bit
// [RQ22] write updates on 26th scl rise; aborted write changes nothing
// [RQ23] matched address is acknowledged by pulling sda low
// [RQ24] write command has top bits 00 then type and converter select
// [RQ25] all bytes travel most significant bit first
`timescale 1ns/100ps
module dsrp_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [3:0] addrStrap,
  input wire logic muteN,
  input wire logic factoryBlank,
  output logic [7:0] convCode0,
  output logic [7:0] convCode1,
  output logic [7:0] convCode2,
  output logic [7:0] convCode3
);
  localparam int NC = dsrp_pkg::NUM_CONV;
  localparam int CW = dsrp_pkg::CODE_W;

  // pin synchronisers, first stage read only by the second
  logic sclM_q, sclS_q, sclD_q, sdaM_q, sdaS_q, sdaD_q;
  logic muteM_q, muteS_q;
  logic [3:0] strapM_q, strapS_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sclM_q, sclS_q, sclD_q, sdaM_q, sdaS_q, sdaD_q} <= 6'h3f;
      {muteM_q, muteS_q} <= 2'h3;
      strapM_q <= 4'h0;
      strapS_q <= 4'h0;
    end else begin
      {sclM_q, sclS_q, sclD_q} <= {sclPin, sclM_q, sclS_q};
      {sdaM_q, sdaS_q, sdaD_q} <= {sdaIn, sdaM_q, sdaS_q};
      {muteM_q, muteS_q} <= {muteN, muteM_q};
      strapM_q <= addrStrap;
      strapS_q <= strapM_q;
    end
  end

  // bus events from the synchronised lines
  logic sclRise, sclFall, startEv, stopEv;
  assign sclRise = sclS_q & ~sclD_q; // RQ9
  assign sclFall = ~sclS_q & sclD_q;
  assign startEv = sclS_q & sclD_q & sdaD_q & ~sdaS_q; // RQ10 RQ11
  assign stopEv = sclS_q & sclD_q & ~sdaD_q & sdaS_q; // RQ10 RQ11

  // write queue between the serial engine and the register store
  dsrp_fifo_if #(.WIDTH(dsrp_pkg::FIFO_WIDTH)) fifoBus ();
  dsrp_fifo #(.WIDTH(dsrp_pkg::FIFO_WIDTH), .DEPTH(dsrp_pkg::FIFO_DEPTH)) uFifo (
    .clk(clk),
    .rst_n(rst_n),
    .bus(fifoBus.fifo)
  );

  logic [CW-1:0] live_q [NC];
  logic [CW-1:0] live_d [NC];
  logic [CW-1:0] stored_q [NC];
  logic [CW-1:0] stored_d [NC];

  // selects a code for read-back, zero for an unused select
  function automatic logic [7:0] pickCode(input logic [7:0] cmd,
                                         input logic [7:0] lv [NC],
                                         input logic [7:0] st [NC]);
    logic [7:0] r;
    r = 8'h00;
    if (cmd[3:2] == 2'h0) begin
      r = cmd[dsrp_pkg::CMD_NV_BIT] ? st[cmd[1:0]] : lv[cmd[1:0]];
    end
    return r;
  endfunction : pickCode

  // serial engine state
  dsrp_pkg::dsrp_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, cmd_q, cmd_d, tx_q, tx_d, rxByte;
  logic ackFlag_q, ackFlag_d, rw_q, rw_d, oeN_q, oeN_d, push;

  // serial engine next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    cmd_d = cmd_q;
    tx_d = tx_q;
    ackFlag_d = ackFlag_q;
    rw_d = rw_q;
    oeN_d = oeN_q;
    push = 1'b0;
    rxByte = {shift_q[6:0], sdaS_q}; // RQ25
    if (stopEv) begin
      state_d = dsrp_pkg::ST_IDLE; // RQ12
      oeN_d = 1'b1;
    end else if (startEv) begin
      state_d = dsrp_pkg::ST_ADDR; // RQ11 RQ13 RQ14
      cnt_d = 4'h0;
      oeN_d = 1'b1;
    end else if (sclRise && state_q != dsrp_pkg::ST_IDLE) begin
      if (cnt_q != dsrp_pkg::ACK_SLOT) begin
        shift_d = rxByte; // RQ20
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == dsrp_pkg::LAST_BIT) begin
          case (state_q)
            dsrp_pkg::ST_ADDR: begin
              ackFlag_d = (rxByte[7:1] == {dsrp_pkg::ADDR_FIXED, strapS_q}); // RQ7 RQ8 RQ19 RQ21
              rw_d = rxByte[0];
            end
            dsrp_pkg::ST_CMD: begin
              cmd_d = rxByte; // RQ20 RQ24
              ackFlag_d = (rxByte[7:6] == dsrp_pkg::OP_WRITE) ||
                          (rxByte[7:6] == dsrp_pkg::OP_READ);
            end
            dsrp_pkg::ST_DATA: begin
              ackFlag_d = (cmd_q[7:6] == dsrp_pkg::OP_WRITE) && fifoBus.wrReady;
              push = ackFlag_d; // RQ22
            end
            default: begin
              ackFlag_d = 1'b0;
            end
          endcase
        end
      end else begin
        // ninth clock: acknowledge sampled, choose next byte
        cnt_d = 4'h0;
        tx_d = pickCode(cmd_q, live_q, stored_q); // RQ6
        case (state_q)
          dsrp_pkg::ST_ADDR: begin
            state_d = !ackFlag_q ? dsrp_pkg::ST_IDLE :
                      (rw_q ? dsrp_pkg::ST_SEND : dsrp_pkg::ST_CMD);
          end
          dsrp_pkg::ST_CMD: begin
            state_d = ackFlag_q ? dsrp_pkg::ST_DATA : dsrp_pkg::ST_IDLE;
          end
          dsrp_pkg::ST_SEND: begin
            state_d = sdaS_q ? dsrp_pkg::ST_IDLE : dsrp_pkg::ST_SEND;
          end
          default: begin
            state_d = dsrp_pkg::ST_IDLE;
          end
        endcase
      end
    end else if (sclFall) begin
      // sda changes only while scl is low
      if (state_q == dsrp_pkg::ST_IDLE) begin
        oeN_d = 1'b1;
      end else if (cnt_q == dsrp_pkg::ACK_SLOT) begin
        oeN_d = !(ackFlag_q && state_q != dsrp_pkg::ST_SEND); // RQ9 RQ23
      end else if (state_q == dsrp_pkg::ST_SEND) begin
        oeN_d = tx_q[3'(dsrp_pkg::LAST_BIT - cnt_q)]; // RQ25
      end else begin
        oeN_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dsrp_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      tx_q <= 8'h00;
      ackFlag_q <= 1'b0;
      rw_q <= 1'b0;
      oeN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      cmd_q <= cmd_d;
      tx_q <= tx_d;
      ackFlag_q <= ackFlag_d;
      rw_q <= rw_d;
      oeN_q <= oeN_d;
    end
  end

  // open-drain pin: data low always, only the enable moves
  assign sdaOut = 1'b0; // RQ17
  assign sdaOeN = oeN_q; // RQ17
  assign fifoBus.wrValid = push;
  assign fifoBus.wrData = {cmd_q, rxByte};

  // register store: copy after reset, then drain queued writes
  logic initBusy_q;
  logic [7:0] qCmd, qDat;
  logic [1:0] qTy;
  assign qCmd = fifoBus.rdData[15:8];
  assign qDat = fifoBus.rdData[7:0];
  assign qTy = {qCmd[dsrp_pkg::CMD_NV_BIT], qCmd[dsrp_pkg::CMD_V_BIT]};
  assign fifoBus.rdReady = ~initBusy_q;

  always_comb begin
    live_d = live_q;
    stored_d = stored_q;
    if (initBusy_q) begin
      live_d = stored_q; // RQ3
    end else if (fifoBus.rdValid) begin
      if (qCmd[3:0] == dsrp_pkg::SEL_ALL) begin
        if (qTy == dsrp_pkg::TY_LIVE) begin
          live_d = '{default: qDat}; // RQ1
        end
      end else if (qCmd[3:2] == 2'h0) begin
        case (qTy)
          dsrp_pkg::TY_COPY: live_d[qCmd[1:0]] = stored_q[qCmd[1:0]]; // RQ5
          dsrp_pkg::TY_LIVE: live_d[qCmd[1:0]] = qDat; // RQ1 RQ5
          dsrp_pkg::TY_STORED: stored_d[qCmd[1:0]] = qDat; // RQ6
          dsrp_pkg::TY_BOTH: begin
            live_d[qCmd[1:0]] = qDat;
            stored_d[qCmd[1:0]] = qDat;
          end
          default: live_d = live_q;
        endcase
      end
    end
    if (factoryBlank) begin
      stored_d = '{default: dsrp_pkg::FACTORY_CODE}; // RQ4
    end
  end

  // live codes and the output stage clear at reset
  logic [CW-1:0] out_q [NC];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      initBusy_q <= 1'b1;
      live_q <= '{default: dsrp_pkg::LIVE_RESET}; // RQ2
      out_q <= '{default: dsrp_pkg::MUTE_CODE};
    end else begin
      initBusy_q <= 1'b0;
      live_q <= live_d;
      for (int i = 0; i < NC; i++) begin
        out_q[i] <= (!muteS_q || initBusy_q) ? dsrp_pkg::MUTE_CODE : live_d[i]; // RQ18 RQ1
      end
    end
  end

  // stored codes are untouched by reset
  always_ff @(posedge clk) begin
    stored_q <= stored_d; // RQ2
  end

  assign convCode0 = out_q[0];
  assign convCode1 = out_q[1];
  assign convCode2 = out_q[2];
  assign convCode3 = out_q[3];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence byteEnd;
    sclRise && cnt_q == dsrp_pkg::LAST_BIT && !startEv && !stopEv;
  endsequence
  sequence liveWrite0;
    fifoBus.rdValid && !initBusy_q && qTy == dsrp_pkg::TY_LIVE &&
        (qCmd[3:0] == 4'h0 || qCmd[3:0] == dsrp_pkg::SEL_ALL);
  endsequence

  sda_never_high_a: assert property (sdaOut == 1'b0) else $error("sda driven high"); // RQ17
  mute_forces_low_a: assert property (!muteS_q |=> out_q[0] == dsrp_pkg::MUTE_CODE &&
      out_q[3] == dsrp_pkg::MUTE_CODE) else $error("mute ignored"); // RQ18
  live_write_out_a: assert property (liveWrite0 and muteS_q |=> live_q[0] == $past(qDat)
      && out_q[0] == live_q[0]) else $error("live write lost"); // RQ1
  init_copy_a: assert property ($rose(rst_n) && initBusy_q |=> live_q[2] == $past(stored_q[2]))
      else $error("stored not copied"); // RQ3
  stop_abort_a: assert property (stopEv |=> state_q == dsrp_pkg::ST_IDLE && !push)
      else $error("stop not taken"); // RQ12
  start_addr_a: assert property (startEv && !stopEv |=> state_q == dsrp_pkg::ST_ADDR &&
      cnt_q == 4'h0) else $error("start not taken"); // RQ11
  foreign_nack_a: assert property (byteEnd and state_q == dsrp_pkg::ST_ADDR &&
      rxByte[7:5] != dsrp_pkg::ADDR_FIXED |=> !ackFlag_q) else $error("foreign address ack"); // RQ7
  push_at_26_a: assert property (push |-> state_q == dsrp_pkg::ST_DATA &&
      cnt_q == dsrp_pkg::LAST_BIT && sclRise) else $error("write at wrong edge"); // RQ22
  sda_low_phase_a: assert property ($changed(oeN_q) |-> $past(sclFall || startEv || stopEv))
      else $error("sda moved with scl high"); // RQ10
  ack_hold_a: assert property (sclFall && cnt_q == dsrp_pkg::ACK_SLOT && ackFlag_q &&
      state_q == dsrp_pkg::ST_ADDR && !startEv && !stopEv |=> !oeN_q)
      else $error("missing acknowledge"); // RQ23
endmodule : dsrp_top

// file: tb/dsrp_master.sv
// two-wire bus master model: drives scl, pulls sda low or releases it
// assumes a pull-up on sda and the 125 MHz clk for phase timing
`timescale 1ns/100ps
module dsrp_master #(
  parameter int QUARTER = 80
) (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaPullN
);
  // bus idles with both lines released high
  initial begin
    sclOut = 1'b1;
    sdaPullN = 1'b1;
  end

  // one quarter of a bit period, about 390 kHz overall
  task automatic wait_q();
    repeat (QUARTER) @(posedge clk);
  endtask : wait_q

  // one clock: sda set while scl low, sampled mid high phase
  task automatic bit_xfer(input logic bIn, output logic bOut);
    sdaPullN <= bIn;
    wait_q();
    sclOut <= 1'b1;
    wait_q();
    bOut = sdaWire;
    wait_q();
    sclOut <= 1'b0;
    wait_q();
  endtask : bit_xfer

  // start or repeated start, scl left low
  task automatic start_cond();
    sdaPullN <= 1'b1;
    wait_q();
    sclOut <= 1'b1;
    wait_q();
    sdaPullN <= 1'b0;
    wait_q();
    sclOut <= 1'b0;
    wait_q();
  endtask : start_cond

  // stop, bus left idle high
  task automatic stop_cond();
    sdaPullN <= 1'b0;
    wait_q();
    sclOut <= 1'b1;
    wait_q();
    sdaPullN <= 1'b1;
    wait_q();
  endtask : stop_cond

  // eight data clocks then the acknowledge clock
  task automatic send_byte(input logic [7:0] b, output logic ackBit);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], dummy);
    end
    bit_xfer(1'b1, ackBit);
  endtask : send_byte

  // receive eight bits, then answer ack or nack
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, b[i]);
    end
    bit_xfer(nack, dummy);
  endtask : recv_byte
endmodule : dsrp_master

// file: tb/dsrp_top_tb.sv
// self-checking bench for the serial register port
// assumes dsrp_master as bus master and a pull-up on the sda wire
`timescale 1ns/100ps
module dsrp_top_tb;
  localparam logic [3:0] STRAP = 4'h5;
  logic clk;
  logic rst_n;
  logic muteN;
  logic factoryBlank;
  logic [3:0] addrStrap;
  logic sclLine;
  logic sdaPullN;
  logic sdaOut;
  logic sdaOeN;
  logic sdaWire;
  logic ack;
  logic [7:0] rdByte;
  logic [7:0] code0;
  logic [7:0] code1;
  logic [7:0] code2;
  logic [7:0] code3;
  logic [7:0] badAddr [4] = '{8'h54, 8'h00, 8'hf0, 8'h6a};
  int miscompares;
  int nTests;

  // open-drain wire with pull-up
  assign sdaWire = (sdaOeN | sdaOut) & sdaPullN;

  dsrp_top dsrp_top_i (.clk(clk), .rst_n(rst_n), .sclPin(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrStrap(addrStrap), .muteN(muteN),
    .factoryBlank(factoryBlank), .convCode0(code0), .convCode1(code1),
    .convCode2(code2), .convCode3(code3));

  dsrp_master #(.QUARTER(80)) dsrp_master_i (.clk(clk), .sdaWire(sdaWire),
    .sclOut(sclLine), .sdaPullN(sdaPullN));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (miscompares == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // bounded wait for all four codes, then compare
  task automatic expect_codes(input logic [31:0] exp);
    int n;
    n = 0;
    while ({code3, code2, code1, code0} !== exp && n < 32) begin
      @(posedge clk);
      n++;
    end
    check({code3, code2, code1, code0}, exp);
  endtask : expect_codes

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset

  // full write: address, command, data, each acknowledged
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat, input logic stop);
    dsrp_master_i.start_cond();
    dsrp_master_i.send_byte({3'h2, STRAP, 1'h0}, ack);
    check({31'h0, ack}, 32'h0);
    dsrp_master_i.send_byte(cmd, ack);
    check({31'h0, ack}, 32'h0);
    dsrp_master_i.send_byte(dat, ack);
    check({31'h0, ack}, 32'h0);
    if (stop) begin
      dsrp_master_i.stop_cond();
    end
  endtask : wr

  // main sequence
  initial begin
    rst_n = 1'b0;
    muteN = 1'b1;
    // stored codes blanked during the first reset so none start unknown
    factoryBlank = 1'b1;
    addrStrap = STRAP;
    miscompares = 0;
    nTests = 0;
    do_reset();
    @(posedge clk);
    factoryBlank <= 1'b0;
    do_reset();
    expect_codes(32'h0);
    wr(8'h11, 8'ha5, 1'b1);
    expect_codes(32'h0000_a500);
    // stored write leaves the output, copy after repeated start loads it
    wr(8'h22, 8'h3c, 1'b0);
    expect_codes(32'h0000_a500);
    wr(8'h02, 8'hff, 1'b1);
    expect_codes(32'h003c_a500);
    wr(8'h33, 8'h5a, 1'b1);
    expect_codes(32'h5a3c_a500);
    // foreign, general call, ten-bit and wrong fixed bits: no acknowledge
    foreach (badAddr[i]) begin
      dsrp_master_i.start_cond();
      dsrp_master_i.send_byte(badAddr[i], ack);
      check({31'h0, ack}, 32'h1);
      dsrp_master_i.stop_cond();
    end
    // stop in mid data byte abandons the write
    dsrp_master_i.start_cond();
    dsrp_master_i.send_byte({3'h2, STRAP, 1'h0}, ack);
    dsrp_master_i.send_byte(8'h11, ack);
    repeat (4) dsrp_master_i.bit_xfer(1'b0, ack);
    dsrp_master_i.stop_cond();
    expect_codes(32'h5a3c_a500);
    // read stored code of converter 2 through a repeated start
    dsrp_master_i.start_cond();
    dsrp_master_i.send_byte({3'h2, STRAP, 1'h0}, ack);
    dsrp_master_i.send_byte(8'ha2, ack);
    dsrp_master_i.start_cond();
    dsrp_master_i.send_byte({3'h2, STRAP, 1'h1}, ack);
    check({31'h0, ack}, 32'h0);
    dsrp_master_i.recv_byte(1'b1, rdByte);
    dsrp_master_i.stop_cond();
    check({24'h0, rdByte}, 32'h0000_003c);
    // mute forces low reference, release restores codes
    muteN <= 1'b0;
    expect_codes(32'h0);
    muteN <= 1'b1;
    expect_codes(32'h5a3c_a500);
    // all-live select loads every live code, stored codes untouched
    wr(8'h1f, 8'h77, 1'b1);
    expect_codes(32'h7777_7777);
    // power cycle: live codes lost, stored codes reloaded
    do_reset();
    expect_codes(32'h5a3c_0000);
    check({31'h0, sdaOut}, 32'h0);
    print_verdict();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : dsrp_top_tb
